// >>> core/ifm_cfg.svh
// Register map, field positions, reset values and timing for the fault monitor
`ifndef IFM_CFG_SVH
`define IFM_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define A_CTRL   8'h00
`define A_STAT   8'h04
`define A_MASK   8'h08
`define A_TEETH  8'h0C
`define A_OVSPD  8'h10
`define A_RSTRNG 8'h14
`define A_TOL    8'h18
`define A_ALARM  8'h1C
`define A_LIMIT  8'h20
`define A_STATE  8'h24
`define A_PERIOD 8'h28
`define A_COUNT  8'h2C

// ****************************************
// Fault bits of status, mask and latch
// ****************************************
`define F_OVSPD 0
`define F_CNT   1
`define F_MISS  2
`define F_CYC   3
`define F_RST   4
`define F_PER   5
`define F_ALARM 6
`define F_TEST  7
`define F_OERR  8
`define F_MISF  9
`define F_STOP  10
`define F_HV    11
`define F_ID    12
`define F_CUR   13
`define F_TEMP  14
`define F_OLIM  15
`define SD_CLASS 16'h147F

// ****************************************
// Control bits, pin vector positions
// ****************************************
`define C_TEST  0
`define C_ACK   1
`define C_OERR  2
`define AL_LO_EN 30
`define AL_HI_EN 31
`define E_TRG   0
`define E_CYC   1
`define E_RST   2
`define L_STOPN 0
`define L_HV    1
`define L_OSW   2
`define L_PRIM  3
`define L_CUR   4
`define L_ID    5

// ****************************************
// Reset values and timing
// ****************************************
`define TEETH_RST  16'h0010
`define OVSPD_RST  24'h000000
`define RSTRNG_RST 16'h0101
`define TOL_RST    3'h2
`define ALARM_RST  32'h0FFF0000
`define LIMIT_RST  32'h0FFF0FFF
`define LV_RST     6'h01
`define CLK_MHZ    20
`define STALL_MS   500

`endif

// >>> core/ifm_pkg.sv
// Types shared by the ignition fault monitor
`default_nettype none

package ifm_pkg;

  typedef enum logic [1:0] {
    ENG_STOP,
    ENG_SEEK,
    ENG_SYNC
  } eng_t;

  typedef struct packed {
    logic [2:0]  ev1;
    logic [2:0]  ev2;
    logic [2:0]  ev3;
    logic [5:0]  lv1;
    logic [5:0]  lv2;
    logic        test;
    logic        oerr_sd;
    logic [15:0] stat;
    logic [15:0] mask;
    logic [15:0] sd;
    logic [15:0] teeth;
    logic [23:0] ovspd;
    logic [15:0] rstrng;
    logic [2:0]  tol;
    logic [31:0] alarm;
    logic [31:0] limit;
    logic [23:0] per_cnt;
    logic [23:0] prev_per;
    logic        prev_ok;
    logic [15:0] ev_cnt;
    logic [7:0]  rst_cnt;
    logic [7:0]  mis_cnt;
    eng_t        eng;
    logic        ign;
    logic        irq;
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } st_t;

endpackage : ifm_pkg

`default_nettype wire

// >>> core/ignition_fault_monitor.sv
// Fault supervision of pickups, limits and output stage for an ignition controller
`include "ifm_cfg.svh"
`default_nettype none

module ignition_fault_monitor #(
  parameter int unsigned STALL_CYC = `STALL_MS * 1000 * `CLK_MHZ
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pickup pins
  input  wire logic        trig_in,
  input  wire logic        cam_in,
  input  wire logic        rst_pick_in,
  // Safety and output stage pins
  input  wire logic        stop_n_in,
  input  wire logic        hv_fault_in,
  input  wire logic        osw_fault_in,
  input  wire logic        prim_open_in,
  input  wire logic        cur_fault_in,
  input  wire logic        id_fault_in,
  // Measured values, same clock
  input  wire logic [11:0] temp_val,
  input  wire logic [11:0] out_val,
  input  wire logic [11:0] alarm_val,
  // Results
  output logic             ign_en,
  output logic             test_run,
  output logic             irq
);

  // ****************************************
  // Constants and helpers
  // ****************************************
  localparam logic [23:0] STALL_TOP = 24'(STALL_CYC - 1);

  function automatic logic out_rng(
    input logic [31:0] v,
    input logic [31:0] lo,
    input logic [31:0] hi
  );
    out_rng = (v < lo) || (v > hi);
  endfunction : out_rng

  function automatic logic [31:0] wide12(
    input logic [11:0] v
  );
    wide12 = {20'h00000, v};
  endfunction : wide12

  // A value equal to its limit is still allowed
  function automatic logic over_lim(
    input logic [11:0] v,
    input logic [11:0] lim
  );
    over_lim = (v > lim);
  endfunction : over_lim

  ifm_pkg::st_t st_r;
  ifm_pkg::st_t st_nxt;

  logic [2:0]  rise;
  logic [15:0] flt;
  logic [15:0] cnt;
  logic [7:0]  rcnt;
  logic [23:0] band;
  logic [24:0] hi_per;
  logic [11:0] a_lo;
  logic [11:0] a_hi;
  logic [11:0] t_lim;
  logic [11:0] o_lim;
  logic [11:0] a_lo_set;
  logic [11:0] a_hi_set;
  logic [7:0]  r_min;
  logic [7:0]  r_max;
  logic        stall;
  logic        setup;
  logic        we;
  logic        ack;
  logic [15:0] w1c;
  logic [15:0] sdc;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    flt    = '0;
    w1c    = '0;
    ack    = 1'b0;
    band   = '0;
    hi_per = '0;

    // Two flops before any logic looks at a pin
    st_nxt.ev1 = {rst_pick_in, cam_in, trig_in};
    st_nxt.ev2 = st_r.ev1;
    st_nxt.ev3 = st_r.ev2;
    st_nxt.lv1 = {id_fault_in, cur_fault_in, prim_open_in,
                  osw_fault_in, hv_fault_in, stop_n_in};
    st_nxt.lv2 = st_r.lv1;
    rise  = st_r.ev2 & ~st_r.ev3;
    cnt   = st_r.ev_cnt + {15'h0000, rise[`E_TRG]};
    rcnt  = st_r.rst_cnt + {7'h00, rise[`E_RST]};
    r_min = st_r.rstrng[7:0];
    r_max = st_r.rstrng[15:8];
    stall = 1'b0;

    // Event period measurement
    if (rise[`E_TRG]) begin
      st_nxt.per_cnt  = '0;
      st_nxt.prev_per = st_r.per_cnt;
      st_nxt.prev_ok  = (st_r.eng != ifm_pkg::ENG_STOP);
      if (st_r.prev_ok) begin
        band   = st_r.prev_per >> st_r.tol;
        hi_per = {1'b0, st_r.prev_per} + {1'b0, band};
        flt[`F_PER] = out_rng({8'h00, st_r.per_cnt},
                              {8'h00, st_r.prev_per - band},
                              {7'h00, hi_per});
        flt[`F_OVSPD] = (st_r.per_cnt < st_r.ovspd);
      end
    end else if (st_r.per_cnt == STALL_TOP) begin
      // Counter parks here, so a stopped engine never wraps into a speed
      stall          = 1'b1;
      st_nxt.prev_ok = 1'b0;
    end else begin
      st_nxt.per_cnt = st_r.per_cnt + 24'h000001;
    end

    // Engine cycle tracking
    case (st_r.eng)
      ifm_pkg::ENG_STOP: begin
        if (rise[`E_TRG]) begin
          st_nxt.eng = ifm_pkg::ENG_SEEK;
        end
      end
      ifm_pkg::ENG_SEEK: begin
        // Counts start only at the first marker; a partial cycle says nothing
        if (rise[`E_CYC]) begin
          st_nxt.eng     = ifm_pkg::ENG_SYNC;
          st_nxt.ev_cnt  = '0;
          st_nxt.rst_cnt = '0;
        end
      end
      ifm_pkg::ENG_SYNC: begin
        st_nxt.ev_cnt  = cnt;
        st_nxt.rst_cnt = rcnt;
        if (rise[`E_TRG] && (st_r.ev_cnt == st_r.teeth)) begin
          flt[`F_CYC] = 1'b1;
        end
        if (rise[`E_CYC]) begin
          flt[`F_CNT]  = (cnt != st_r.teeth);
          flt[`F_MISS] = (cnt < st_r.teeth);
          flt[`F_RST]  = out_rng({24'h000000, rcnt},
                                 {24'h000000, r_min},
                                 {24'h000000, r_max});
          st_nxt.ev_cnt  = '0;
          st_nxt.rst_cnt = '0;
        end
      end
      default: begin
        st_nxt.eng = ifm_pkg::ENG_STOP;
      end
    endcase
    if (stall) begin
      st_nxt.eng = ifm_pkg::ENG_STOP;
    end

    // Misfire count for runtime data, saturating
    if (rise[`E_TRG] && st_r.lv2[`L_PRIM] && (st_r.mis_cnt != 8'hFF)) begin
      st_nxt.mis_cnt = st_r.mis_cnt + 8'h01;
    end

    // ****************************************
    // Register writes
    // ****************************************
    setup = psel && !penable;
    we    = psel && penable && pwrite && st_r.ready;
    if (we) begin
      case (paddr)
        `A_CTRL: begin
          st_nxt.test    = pwdata[`C_TEST];
          st_nxt.oerr_sd = pwdata[`C_OERR];
          ack = pwdata[`C_ACK] && (st_r.eng == ifm_pkg::ENG_STOP);
        end
        `A_STAT: begin
          w1c = pwdata[15:0];
        end
        `A_MASK: begin
          st_nxt.mask = pwdata[15:0];
        end
        `A_TEETH: begin
          st_nxt.teeth = pwdata[15:0];
        end
        `A_OVSPD: begin
          st_nxt.ovspd = pwdata[23:0];
        end
        `A_RSTRNG: begin
          st_nxt.rstrng = pwdata[15:0];
        end
        `A_TOL: begin
          st_nxt.tol = pwdata[2:0];
        end
        `A_ALARM: begin
          st_nxt.alarm = pwdata;
        end
        `A_LIMIT: begin
          st_nxt.limit = pwdata;
        end
        default: begin
          st_nxt.test = st_nxt.test;
        end
      endcase
    end

    // ****************************************
    // Level faults
    // ****************************************
    // Bits 31 and 30 arm the upper and lower alarm limit
    t_lim    = st_r.limit[11:0];
    o_lim    = st_r.limit[27:16];
    a_lo_set = st_r.alarm[11:0];
    a_hi_set = st_r.alarm[27:16];
    a_lo = st_r.alarm[`AL_LO_EN] ? a_lo_set : 12'h000;
    a_hi = st_r.alarm[`AL_HI_EN] ? a_hi_set : 12'hFFF;
    flt[`F_ALARM] = out_rng(wide12(alarm_val), wide12(a_lo), wide12(a_hi));
    flt[`F_OERR] = st_r.lv2[`L_HV] || st_r.lv2[`L_OSW];
    flt[`F_MISF] = st_r.lv2[`L_PRIM];
    flt[`F_STOP] = !st_r.lv2[`L_STOPN];
    flt[`F_HV]   = st_r.lv2[`L_HV];
    flt[`F_ID]   = st_r.lv2[`L_ID];
    flt[`F_CUR]  = st_r.lv2[`L_CUR];
    flt[`F_TEMP] = over_lim(temp_val, t_lim);
    flt[`F_OLIM] = over_lim(out_val, o_lim);

    // Abort beats a start written in the same cycle
    if (st_nxt.test && (|rise)) begin
      flt[`F_TEST] = 1'b1;
      st_nxt.test  = 1'b0;
    end

    // ****************************************
    // Status, latch, outputs
    // ****************************************
    // A fault in the clearing cycle stays set
    st_nxt.stat = (st_r.stat & ~w1c) | flt;
    sdc = `SD_CLASS;
    if (st_r.oerr_sd) begin
      sdc[`F_OERR] = 1'b1;
    end
    st_nxt.sd  = (ack ? 16'h0000 : st_r.sd) | (flt & sdc);
    st_nxt.ign = (st_nxt.sd == 16'h0000);
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

    // ****************************************
    // Read data, answered in the first access cycle
    // ****************************************
    st_nxt.ready  = setup;
    st_nxt.slverr = 1'b0;
    if (setup && !pwrite) begin
      case (paddr)
        `A_CTRL: begin
          st_nxt.rdata = {29'h00000000, st_r.oerr_sd, 1'b0, st_r.test};
        end
        `A_STAT: begin
          st_nxt.rdata = {16'h0000, st_r.stat};
        end
        `A_MASK: begin
          st_nxt.rdata = {16'h0000, st_r.mask};
        end
        `A_TEETH: begin
          st_nxt.rdata = {16'h0000, st_r.teeth};
        end
        `A_OVSPD: begin
          st_nxt.rdata = {8'h00, st_r.ovspd};
        end
        `A_RSTRNG: begin
          st_nxt.rdata = {16'h0000, st_r.rstrng};
        end
        `A_TOL: begin
          st_nxt.rdata = {29'h00000000, st_r.tol};
        end
        `A_ALARM: begin
          st_nxt.rdata = st_r.alarm;
        end
        `A_LIMIT: begin
          st_nxt.rdata = st_r.limit;
        end
        `A_STATE: begin
          st_nxt.rdata = {st_r.sd, 12'h000, st_r.eng, st_r.test, st_r.ign};
        end
        `A_PERIOD: begin
          st_nxt.rdata = {8'h00, st_r.prev_per};
        end
        `A_COUNT: begin
          st_nxt.rdata = {st_r.mis_cnt, st_r.rst_cnt, st_r.ev_cnt};
        end
        default: begin
          st_nxt.rdata  = 32'h00000000;
          st_nxt.slverr = 1'b1;
        end
      endcase
    end else if (setup) begin
      st_nxt.rdata  = 32'h00000000;
      st_nxt.slverr = !((paddr <= `A_COUNT) && (paddr[1:0] == 2'h0));
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= '0;
      st_r.lv1    <= `LV_RST;
      st_r.lv2    <= `LV_RST;
      st_r.teeth  <= `TEETH_RST;
      st_r.ovspd  <= `OVSPD_RST;
      st_r.rstrng <= `RSTRNG_RST;
      st_r.tol    <= `TOL_RST;
      st_r.alarm  <= `ALARM_RST;
      st_r.limit  <= `LIMIT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata   = st_r.rdata;
  assign pready   = st_r.ready;
  assign pslverr  = st_r.slverr;
  assign ign_en   = st_r.ign;
  assign test_run = st_r.test;
  assign irq      = st_r.irq;

endmodule : ignition_fault_monitor

`default_nettype wire

// >>> testbench/pickup_model.sv
// Pickup stream model: trigger teeth, cycle marker and reset pulses
`default_nettype none

module pickup_model (
  // Clock and control
  input  wire logic       pclk,
  input  wire logic       run,
  input  wire logic [7:0] n,
  input  wire logic [7:0] gap,
  input  wire logic [1:0] nr,
  // Pickup lines, idle low
  output logic            trg,
  output logic            cyc,
  output logic            rsp
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    trg = 1'b0;
    cyc = 1'b0;
    rsp = 1'b0;
    @(posedge pclk);
    forever begin
      if (run) begin
        for (int i = 0; i < n; i++) begin
          trg <= 1'b1;
          repeat (3) @(posedge pclk);
          trg <= 1'b0;
          if (i == n - 1) begin
            // Marker sits inside the last gap so the period stays even
            cyc <= 1'b1;
            repeat (3) @(posedge pclk);
            cyc <= 1'b0;
            for (int k = 0; k < nr; k++) begin
              rsp <= 1'b1;
              repeat (3) @(posedge pclk);
              rsp <= 1'b0;
              repeat (3) @(posedge pclk);
            end
            repeat (gap - 6 - 6 * nr) @(posedge pclk);
          end else begin
            repeat (gap - 3) @(posedge pclk);
          end
        end
      end else begin
        @(posedge pclk);
      end
    end
  end

endmodule : pickup_model

`default_nettype wire

// >>> testbench/ifm_chk.sv
// Port-level assertions for the ignition fault monitor
`default_nettype none

module ifm_chk (
  // Clock, reset and APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and results
  input wire logic        trig_in,
  input wire logic        stop_n_in,
  input wire logic        id_fault_in,
  input wire logic        ign_en,
  input wire logic        test_run
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] up_r;
  logic       wr;

  assign wr = psel && penable && pready && pwrite;

  // Ignition may open by itself just after reset, so wait until settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_r <= 3'h0;
    end else if (up_r != 3'h7) begin
      up_r <= up_r + 3'h1;
    end
  end

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_stop_kills: assert property (!stop_n_in |-> ##[1:6] !ign_en)
    else $error("ignition open under stop contact");
  a_id_kills: assert property (id_fault_in |-> ##[1:6] !ign_en)
    else $error("ignition open with output board fault");
  a_test_abort: assert property (test_run && $rose(trig_in) |-> ##[1:6] !test_run)
    else $error("self test not aborted");
  a_latch_hold: assert property (up_r == 3'h7 && !ign_en && !wr && !$past(wr)
    && !$past(wr, 2) |=> !ign_en)
    else $error("ignition reopened without acknowledge");

endmodule : ifm_chk

bind ignition_fault_monitor ifm_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .trig_in, .stop_n_in, .id_fault_in, .ign_en, .test_run);

`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the ignition fault monitor
`default_nettype none
`include "ifm_cfg.svh"

`define CHK(a, b) \
  begin \
    checks_done++; \
    if ((a) !== (b)) begin \
      failures++; \
      $display("[FAIL] %0t: got %h want %h", $time, (a), (b)); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [31:0] m;
    logic [31:0] e;
    logic        er;
  } exp_t;

  // Fault order: stop, hv, switch, current, id, temp, output, alarm high, alarm low
  localparam logic [15:0] EX[9] = '{16'h0400, 16'h0900, 16'h0100, 16'h2000, 16'h1000,
                                    16'h4000, 16'h8000, 16'h0040, 16'h0040};
  localparam logic [8:0]  KILL  = 9'h197;
  localparam logic [7:0]  RA[8] = '{`A_TEETH, `A_OVSPD, `A_RSTRNG, `A_TOL, `A_ALARM,
                                    `A_LIMIT, 8'h30, 8'h02};
  localparam logic [31:0] RV[8] = '{`TEETH_RST, `OVSPD_RST, `RSTRNG_RST, `TOL_RST,
                                    `ALARM_RST, `LIMIT_RST, 32'h0, 32'h0};

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        ign_en, test_run, irq, run, prim;
  logic [7:0]  paddr, n, gap;
  logic [31:0] pwdata, prdata;
  logic [1:0]  nr;
  logic [8:0]  f;
  logic [15:0] msk;
  wire logic   trg, cyc, rsp;
  int          failures = 0;
  int          checks_done = 0;
  exp_t        q[$];
  exp_t        x;

  ignition_fault_monitor #(.STALL_CYC(200)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .trig_in(trg), .cam_in(cyc), .rst_pick_in(rsp), .stop_n_in(~f[0]),
    .hv_fault_in(f[1]), .osw_fault_in(f[2]), .prim_open_in(prim), .cur_fault_in(f[3]),
    .id_fault_in(f[4]), .temp_val(f[5] ? 12'h020 : 12'h008),
    .out_val(f[6] ? 12'h020 : 12'h008),
    .alarm_val(f[7] ? 12'h200 : (f[8] ? 12'h000 : 12'h080)),
    .ign_en, .test_run, .irq);

  pickup_model i_pick (.pclk, .run, .n, .gap, .nr, .trg, .cyc, .rsp);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ****
  // Bus tasks
  // ****
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic er);
    q.push_back('{m, e, er});
    xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic clr();
    wr(`A_STAT, 32'hFFFF);
    wr(`A_CTRL, 32'h6);
    repeat (2) @(posedge pclk);
  endtask : clr

  task automatic step(input logic [7:0] nn, g, g2, input logic [1:0] r, input logic pr,
                      input logic [23:0] ov, input logic [15:0] e);
    wr(`A_OVSPD, {8'h0, ov});
    n <= nn;
    gap <= g;
    nr <= r;
    prim <= pr;
    run <= 1'b1;
    repeat (700) @(posedge pclk);
    wr(`A_STAT, 32'hFFFF);
    gap <= g2;
    repeat (500) @(posedge pclk);
    rd(`A_STAT, 32'h023F, {16'h0, e}, 1'b0);
    // Acknowledge while turning must be ignored
    wr(`A_CTRL, 32'h6);
    repeat (2) @(posedge pclk);
    `CHK(ign_en, ~|(e & `SD_CLASS))
    run <= 1'b0;
    prim <= 1'b0;
    repeat (500) @(posedge pclk);
    clr();
    `CHK(ign_en, 1'b1)
  endtask : step

  task automatic tally_and_finish();
    $display("checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // ****
  // Read monitor and sequence
  // ****
  always @(posedge pclk) begin
    if ((psel && penable && pready && !pwrite) === 1'b1) begin
      x = q.pop_front();
      `CHK({pslverr, prdata & x.m}, {x.er, x.e})
    end
  end

  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    $display("[FAIL] %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    void'($urandom(1));
    {presetn, psel, penable, pwrite, run, prim} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    f = 9'h0;
    n = 8'd4;
    gap = 8'd40;
    nr = 2'd1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK(ign_en, 1'b1)
    for (int i = 0; i < 8; i++) begin
      rd(RA[i], 32'hFFFF_FFFF, RV[i], i > 5);
    end
    rd(`A_STATE, 32'hFFFF_000F, 32'h0000_0001, 1'b0);
    msk = 16'($urandom);
    wr(`A_MASK, {16'h0, msk});
    rd(`A_MASK, 32'hFFFF_FFFF, {16'h0, msk}, 1'b0);
    wr(`A_TEETH, 32'h4);
    wr(`A_LIMIT, 32'h0010_0010);
    wr(`A_ALARM, 32'hC100_0010);
    clr();
    for (int i = 0; i < 9; i++) begin
      f[i] <= 1'b1;
      repeat (8) @(posedge pclk);
      rd(`A_STAT, {16'h0, EX[i]}, {16'h0, EX[i]}, 1'b0);
      `CHK(ign_en, !KILL[i])
      `CHK(irq, |(msk & EX[i]))
      f[i] <= 1'b0;
      repeat (8) @(posedge pclk);
      `CHK(ign_en, !KILL[i])
      clr();
      `CHK(ign_en, 1'b1)
      `CHK(irq, 1'b0)
    end
    step(8'd4, 8'd40, 8'd40, 2'd1, 1'b0, 24'h0, 16'h0000);
    step(8'd3, 8'd40, 8'd40, 2'd1, 1'b0, 24'h0, 16'h0006);
    step(8'd5, 8'd40, 8'd40, 2'd1, 1'b0, 24'h0, 16'h000A);
    step(8'd4, 8'd40, 8'd40, 2'd0, 1'b0, 24'h0, 16'h0010);
    step(8'd4, 8'd40, 8'd20, 2'd1, 1'b0, 24'h0, 16'h0020);
    step(8'd4, 8'd40, 8'd40, 2'd1, 1'b1, 24'd60, 16'h0201);
    wr(`A_CTRL, 32'h5);
    repeat (2) @(posedge pclk);
    `CHK(test_run, 1'b1)
    run <= 1'b1;
    repeat (60) @(posedge pclk);
    `CHK(test_run, 1'b0)
    rd(`A_STAT, 32'h0080, 32'h0080, 1'b0);
    run <= 1'b0;
    repeat (500) @(posedge pclk);
    clr();
    rd(`A_PERIOD, 32'hFFFF_FFFF, 32'd39, 1'b0);
    tally_and_finish();
  end

endmodule : tb_top

`default_nettype wire
